/* File: verilog/vpw_defs.svh */
`ifndef VPW_DEFS_SVH
`define VPW_DEFS_SVH
// Bus clock and the 1 us symbol tick
`define VPW_CLK_MHZ 25
`define VPW_TICK_US 1
`define VPW_TICK_CYCLES (`VPW_CLK_MHZ * `VPW_TICK_US)
// Register byte offsets
`define VPW_OFF_CTRL1 8'h00
`define VPW_OFF_CTRL2 8'h04
`define VPW_OFF_STATE 8'h08
`define VPW_OFF_DATA 8'h0C
`define VPW_OFF_FLAGS 8'h10
// Field positions
`define VPW_C1_IE 0
`define VPW_C2_LOOP 0
`define VPW_C2_FAST 1
`define VPW_FL_RXB 0
`define VPW_FL_TXE 1
// Reset values
`define VPW_IE_RST 1'h0
`define VPW_LOOP_RST 1'h0
`define VPW_FAST_RST 1'h0
// State vector codes
`define VPW_CODE_NONE 8'h00
`define VPW_CODE_TXE 8'h0A
`define VPW_CODE_RXB 8'h0C
`define VPW_CODE_LOA 8'h14
`define VPW_CODE_CRC 8'h18
`define VPW_CODE_INV 8'h1C
// CRC preset and good residue
`define VPW_CRC_PRESET 8'hFF
`define VPW_CRC_POLY 8'h1D
`define VPW_CRC_GOOD 8'hC4
// Receive limits in us ticks, normal speed
`define VPW_T_INV 9'h022
`define VPW_T_SHORT 9'h060
`define VPW_T_LONG 9'h0A3
`define VPW_T_SOF 9'h0EF
`define VPW_T_IDLE 9'h12C
// Receive limits in us ticks, fourfold speed
`define VPW_F_INV 9'h009
`define VPW_F_SHORT 9'h018
`define VPW_F_LONG 9'h029
`define VPW_F_SOF 9'h03C
// Transmit symbol lengths in us ticks
`define VPW_TX_SHORT 9'h040
`define VPW_TX_LONG 9'h080
`define VPW_TX_SOF 9'h0C8
`define VPW_TX_ECHO 9'h010
`endif

/* File: verilog/vpw_pkg.sv */
package vpw_pkg;
   // Pending state vector events
   typedef struct packed {
      logic loa;
      logic inv;
      logic crc;
      logic rxb;
      logic txe;
   } vpw_evt_t;
   // Transmit sequencer
   typedef enum logic [1:0] {TX_IDLE, TX_SOF, TX_BITS, TX_EOD} vpw_tx_state_t;
   // Receive framer
   typedef enum logic [1:0] {RX_WAIT_IDLE, RX_WAIT_SOF, RX_FRAME} vpw_rx_state_t;
endpackage

/* File: verilog/vpw_protocol_handler.sv */
// Function
// - Frame, arbitrate, generate and check CRC, detect errors on every frame.
// - Full received byte goes to holding buffer, flag set, interrupt if enabled.
// - Finished transmit byte reloads from holding buffer, then empty flag sets.
// - Loopback selector feeds receive path from transmit pin or receive pin.
// - Never transmit at fourfold speed; receive it when fast enable is set.
// - Fourfold traffic is ignored as noise while fast enable is clear.
// - Receive frames of any byte count framed by SOF, CRC and EOD.
// - No maximum transmit length; frame runs while software supplies bytes.
// - Own frame with invalid bits or misplaced framing stops, code 1C, interrupt.
// - After data and CRC, residue other than C4 flags code 18.
// - Invalid received symbol gives 1C; while transmitting 14 first, 1C queued.
// - EOD or EOF off byte boundary, or active during own EOD, gives 1C.
// - Bus held active: wait for passive, start nothing while short lasts.
// - Bus held passive: started frame fails, code 1C, abort, await new command.
// - After a temporary fault clears, operation resumes without reset.
// - Break gives 1C, cleared by state read; then wait idle, then SOF (code flags 1C only for a break inside a frame).
// - Break symbols are only received, never generated.
// - After a CRC error discard the frame and wait for next SOF.
// - Noise giving invalid bits in own frame aborts it and flags 1C.
// - Dominant bit read back where recessive was sent loses arbitration at once.
// - Loss on eighth bit of a data byte appends up to two arbitrated ones bits.
// - Passive longer than idle threshold is idle; pending frame may start.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "vpw_defs.svh"
module vpw_protocol_handler
   import vpw_pkg::*;
#(
   parameter int CLK_DIV = `VPW_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bus_receive_pin,
   output logic bus_transmit_pin,
   output logic irq
);
   // Divider must fit its counter and leave room for assertions
   if (CLK_DIV < 10 || CLK_DIV > 255) begin : g_bad_div
      $error("CLK_DIV out of range");
   end

   // One-bit step of the bus CRC, MSB first
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      crc_step = {c[6:0], 1'h0} ^ ((c[7] ^ b) ? `VPW_CRC_POLY : 8'h00);
   endfunction

   logic [7:0] tick_cnt_reg;
   logic tick_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;
   logic irq_en_reg;
   logic loop_reg;
   logic fast_reg;
   vpw_evt_t pend_reg;
   vpw_evt_t rx_evt_reg;
   vpw_evt_t tx_evt_reg;
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic rxd_q;
   logic [8:0] rx_cnt_reg;
   vpw_rx_state_t rx_state;
   logic rx_fast_reg;
   logic [7:0] rx_shift_reg;
   logic [7:0] rx_crc_reg;
   logic [2:0] rx_bitcnt_reg;
   logic [7:0] rx_buf_reg;
   vpw_tx_state_t tx_state;
   logic tx_pin_reg;
   logic [7:0] tx_buf_reg;
   logic tx_full_reg;
   logic [7:0] tx_shift_reg;
   logic [7:0] tx_crc_reg;
   logic [2:0] tx_bitcnt_reg;
   logic tx_crc_sent_reg;
   logic [1:0] tx_extra_reg;
   logic [8:0] tx_cnt_reg;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign bus_transmit_pin = tx_pin_reg;

   // Symbol tick divider, one pulse per microsecond
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 8'h00;
         tick_reg <= 1'h0;
      end else begin
         tick_reg <= (tick_cnt_reg == 8'(CLK_DIV - 1));
         tick_cnt_reg <= (tick_cnt_reg == 8'(CLK_DIV - 1)) ? 8'h00 : tick_cnt_reg + 8'h01;
      end
   end

   // APB decode
   wire setup = psel & ~penable;
   wire wr = psel & penable & pready_reg & pwrite;
   wire rd = psel & penable & pready_reg & ~pwrite;
   wire a_c1 = (paddr == `VPW_OFF_CTRL1);
   wire a_c2 = (paddr == `VPW_OFF_CTRL2);
   wire a_sv = (paddr == `VPW_OFF_STATE);
   wire a_dt = (paddr == `VPW_OFF_DATA);
   wire a_fl = (paddr == `VPW_OFF_FLAGS);
   wire mapped = a_c1 | a_c2 | a_sv | a_dt | a_fl;

   // State vector, highest pending source first; loss ahead of invalid
   wire [7:0] sv_code = pend_reg.loa ? `VPW_CODE_LOA :
                        pend_reg.inv ? `VPW_CODE_INV :
                        pend_reg.crc ? `VPW_CODE_CRC :
                        pend_reg.rxb ? `VPW_CODE_RXB :
                        pend_reg.txe ? `VPW_CODE_TXE : `VPW_CODE_NONE;

   // Read data selection
   wire [31:0] rd_data = a_c1 ? {31'h0, irq_en_reg} :
                         a_c2 ? {30'h0, fast_reg, loop_reg} :
                         a_sv ? {24'h0, sv_code} :
                         a_dt ? {24'h0, rx_buf_reg} :
                         a_fl ? {30'h0, pend_reg.txe, pend_reg.rxb} : 32'h0;

   // Read answer captured in setup, stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'h0;
         pready_reg <= 1'h0;
      end else begin
         pready_reg <= 1'h1;
         if (setup) begin
            prdata_reg <= pwrite ? 32'h0 : rd_data;
            pslverr_reg <= ~mapped;
         end
      end
   end

   // Control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_reg <= `VPW_IE_RST;
         loop_reg <= `VPW_LOOP_RST;
         fast_reg <= `VPW_FAST_RST;
      end else if (wr && a_c1) begin
         irq_en_reg <= pwdata[`VPW_C1_IE];
      end else if (wr && a_c2) begin
         loop_reg <= pwdata[`VPW_C2_LOOP];
         fast_reg <= pwdata[`VPW_C2_FAST];
      end
   end

   // Clears from reads and writes; the reported code is the captured one
   wire sv_rd = rd & a_sv;
   vpw_evt_t pend_clr;
   vpw_evt_t pend_set;
   assign pend_clr.loa = sv_rd & (prdata_reg[7:0] == `VPW_CODE_LOA);
   assign pend_clr.inv = sv_rd & (prdata_reg[7:0] == `VPW_CODE_INV);
   assign pend_clr.crc = sv_rd & (prdata_reg[7:0] == `VPW_CODE_CRC);
   assign pend_clr.rxb = (sv_rd & (prdata_reg[7:0] == `VPW_CODE_RXB)) | (rd & a_dt);
   assign pend_clr.txe = (sv_rd & (prdata_reg[7:0] == `VPW_CODE_TXE)) | (wr & a_dt);
   assign pend_set = rx_evt_reg | tx_evt_reg;

   // Pending events, a set wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 5'b00001;
         irq_reg <= 1'h0;
      end else begin
         pend_reg <= vpw_evt_t'((pend_reg & ~pend_clr) | pend_set);
         irq_reg <= irq_en_reg & (|pend_reg);
      end
   end

   // Receive pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta_reg <= 1'h0;
         rx_sync_reg <= 1'h0;
      end else begin
         rx_meta_reg <= bus_receive_pin;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // Loopback selector
   wire rxd_w = loop_reg ? tx_pin_reg : rx_sync_reg;

   // Receive symbol classification
   wire rx_edge = (rxd_w != rxd_q);
   wire [8:0] t_inv = rx_fast_reg ? `VPW_F_INV : `VPW_T_INV;
   wire [8:0] t_short = rx_fast_reg ? `VPW_F_SHORT : `VPW_T_SHORT;
   wire [8:0] t_long = rx_fast_reg ? `VPW_F_LONG : `VPW_T_LONG;
   wire d_inv = (rx_cnt_reg < t_inv);
   wire d_short = (rx_cnt_reg < t_short);
   wire d_long = (rx_cnt_reg < t_long);
   wire rx_bit = d_short ? rxd_q : ~rxd_q;
   wire brk = rxd_q & (rx_cnt_reg >= `VPW_T_SOF);
   wire sof_1x = (rx_cnt_reg >= `VPW_T_LONG) && (rx_cnt_reg < `VPW_T_SOF);
   wire sof_4x = fast_reg && (rx_cnt_reg >= `VPW_F_LONG) && (rx_cnt_reg < `VPW_F_SOF);
   wire noise_ok = !rx_fast_reg && !fast_reg && (rx_cnt_reg >= `VPW_F_INV);
   wire eod_hit = (rx_state == RX_FRAME) && !rxd_q && !rx_edge && !d_long;
   wire bus_idle = !rxd_q && (rx_cnt_reg >= `VPW_T_IDLE);
   wire tx_busy = (tx_state != TX_IDLE);
   wire [7:0] rx_crc_n = crc_step(rx_crc_reg, rx_bit);

   // Receive framer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_q <= 1'h0;
         rx_cnt_reg <= 9'h000;
         rx_state <= RX_WAIT_IDLE;
         rx_fast_reg <= 1'h0;
         rx_shift_reg <= 8'h00;
         rx_crc_reg <= `VPW_CRC_PRESET;
         rx_bitcnt_reg <= 3'h0;
         rx_buf_reg <= 8'h00;
         rx_evt_reg <= '0;
      end else begin
         rx_evt_reg <= '0;
         rxd_q <= rxd_w;
         if (rx_edge) begin
            rx_cnt_reg <= 9'h000;
         end else if (tick_reg && rx_cnt_reg != 9'h1FF) begin
            rx_cnt_reg <= rx_cnt_reg + 9'h001;
         end
         case (rx_state)
            RX_WAIT_IDLE: begin
               if (bus_idle) begin
                  rx_state <= RX_WAIT_SOF;
               end
            end
            RX_WAIT_SOF: begin
               if (rx_edge && rxd_q && (sof_1x || sof_4x)) begin
                  rx_state <= RX_FRAME;
                  rx_fast_reg <= !sof_1x;
                  rx_crc_reg <= `VPW_CRC_PRESET;
                  rx_bitcnt_reg <= 3'h0;
               end else if (rx_edge && brk) begin
                  rx_state <= RX_WAIT_IDLE;
               end
            end
            default: begin
               if (eod_hit) begin
                  // End of data: boundary, then residue; frame is dropped
                  rx_state <= RX_WAIT_SOF;
                  rx_fast_reg <= 1'h0;
                  rx_evt_reg.inv <= (rx_bitcnt_reg != 3'h0);
                  rx_evt_reg.crc <= (rx_bitcnt_reg == 3'h0) && (rx_crc_reg != `VPW_CRC_GOOD);
               end else if (rx_edge && brk) begin
                  rx_state <= RX_WAIT_IDLE;
                  rx_evt_reg.inv <= 1'h1;
                  rx_evt_reg.loa <= tx_busy;
               end else if (rx_edge && d_inv && noise_ok && !tx_busy) begin
                  rx_state <= RX_WAIT_SOF;
                  rx_fast_reg <= 1'h0;
               end else if (rx_edge && (d_inv || !d_long)) begin
                  rx_state <= RX_WAIT_SOF;
                  rx_fast_reg <= 1'h0;
                  rx_evt_reg.inv <= 1'h1;
                  rx_evt_reg.loa <= tx_busy;
               end else if (rx_edge) begin
                  // Data bit; no byte limit within a frame
                  rx_shift_reg <= {rx_shift_reg[6:0], rx_bit};
                  rx_crc_reg <= rx_crc_n;
                  rx_bitcnt_reg <= rx_bitcnt_reg + 3'h1;
                  if (rx_bitcnt_reg == 3'h7) begin
                     rx_buf_reg <= {rx_shift_reg[6:0], rx_bit};
                     rx_evt_reg.rxb <= 1'h1;
                  end
               end
            end
         endcase
      end
   end

   // Transmit symbol timing, normal speed only
   wire tx_bit = tx_shift_reg[7];
   wire [8:0] tx_dur = (tx_state != TX_BITS) ? `VPW_TX_SOF :
                       (tx_pin_reg ^ tx_bit) ? `VPW_TX_LONG : `VPW_TX_SHORT;
   wire tx_end = (tx_cnt_reg + 9'h001) >= tx_dur;
   wire echo_late = (tx_cnt_reg > `VPW_TX_ECHO);
   wire stuck_low = tx_pin_reg && !rxd_q && echo_late;
   wire tx_hit = !tx_pin_reg && rxd_q && echo_late;
   wire [7:0] tx_crc_n = crc_step(tx_crc_reg, tx_bit);

   // Transmit decisions
   wire tx_start = !tx_busy && tx_full_reg && bus_idle && (rx_state != RX_FRAME);
   wire tx_err_inv = tick_reg && tx_busy && (stuck_low ||
                     (tx_hit && (tx_state == TX_EOD || !tx_bit)));
   wire tx_loss = tick_reg && tx_hit && !stuck_low && (tx_state == TX_BITS) && tx_bit;
   wire tx_append = tx_loss && (tx_bitcnt_reg == 3'h7) && (tx_extra_reg == 2'h0) && !tx_crc_sent_reg;
   wire tx_fin = tick_reg && tx_end && !tx_hit && !stuck_low &&
                 (tx_state == TX_EOD || (tx_state == TX_BITS && tx_extra_reg == 2'h1));
   wire tx_stop = tx_busy && (rx_evt_reg.inv || tx_err_inv || (tx_loss && !tx_append) || tx_fin);

   // Transmit sequencer with holding buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= TX_IDLE;
         tx_pin_reg <= 1'h0;
         tx_buf_reg <= 8'h00;
         tx_full_reg <= 1'h0;
         tx_shift_reg <= 8'h00;
         tx_crc_reg <= `VPW_CRC_PRESET;
         tx_bitcnt_reg <= 3'h0;
         tx_crc_sent_reg <= 1'h0;
         tx_extra_reg <= 2'h0;
         tx_cnt_reg <= 9'h000;
         tx_evt_reg <= '0;
      end else begin
         tx_evt_reg <= '0;
         if (tx_start) begin
            tx_state <= TX_SOF;
            tx_pin_reg <= 1'h1;
            tx_shift_reg <= tx_buf_reg;
            tx_full_reg <= 1'h0;
            tx_evt_reg.txe <= 1'h1;
            tx_crc_reg <= `VPW_CRC_PRESET;
            tx_bitcnt_reg <= 3'h0;
            tx_crc_sent_reg <= 1'h0;
            tx_extra_reg <= 2'h0;
            tx_cnt_reg <= 9'h000;
         end else if (tx_stop) begin
            // Abort or normal end; a fresh write is needed to start again
            tx_state <= TX_IDLE;
            tx_pin_reg <= 1'h0;
            tx_full_reg <= 1'h0;
            tx_evt_reg.inv <= tx_err_inv;
            tx_evt_reg.loa <= tx_loss;
         end else if (tx_append) begin
            tx_extra_reg <= 2'h2;
            tx_shift_reg <= 8'hFF;
            tx_cnt_reg <= 9'h000;
            tx_evt_reg.loa <= 1'h1;
         end else if (tx_busy && tick_reg) begin
            if (!tx_end) begin
               tx_cnt_reg <= tx_cnt_reg + 9'h001;
            end else if (tx_state == TX_SOF) begin
               tx_cnt_reg <= 9'h000;
               tx_state <= TX_BITS;
               tx_pin_reg <= 1'h0;
            end else begin
               tx_cnt_reg <= 9'h000;
               tx_pin_reg <= ~tx_pin_reg;
               tx_shift_reg <= {tx_shift_reg[6:0], 1'h1};
               tx_crc_reg <= tx_crc_n;
               if (tx_extra_reg != 2'h0) begin
                  tx_extra_reg <= tx_extra_reg - 2'h1;
               end else begin
                  tx_bitcnt_reg <= tx_bitcnt_reg + 3'h1;
               end
               if (tx_extra_reg == 2'h0 && tx_bitcnt_reg == 3'h7) begin
                  if (tx_crc_sent_reg) begin
                     tx_state <= TX_EOD;
                  end else if (tx_full_reg) begin
                     tx_shift_reg <= tx_buf_reg;
                     tx_full_reg <= 1'h0;
                     tx_evt_reg.txe <= 1'h1;
                  end else begin
                     tx_shift_reg <= ~tx_crc_n;
                     tx_crc_sent_reg <= 1'h1;
                  end
               end
            end
         end
         if (wr && a_dt) begin
            tx_buf_reg <= pwdata[7:0];
            tx_full_reg <= 1'h1;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_byte_done;
      rx_evt_reg.rxb;
   endsequence
   sequence s_flag_up;
      pend_reg.rxb && (rx_buf_reg == $past(rx_buf_reg));
   endsequence

   a_rx_byte_flag: assert property (s_byte_done |=> s_flag_up)
      else $error("received byte did not raise ready flag");
   a_tx_load_empty: assert property (tx_evt_reg.txe |=> pend_reg.txe)
      else $error("transmit load did not set empty flag");
   a_loop_select: assert property (loop_reg && $rose(tx_pin_reg) && !tx_start |=> rxd_q)
      else $error("loopback did not echo transmit pin");
   a_sof_normal: assert property (($past(tx_state) == TX_SOF) && $fell(tx_pin_reg) && (tx_state == TX_BITS)
      |-> $past(tx_cnt_reg) == (`VPW_TX_SOF - 9'h001))
      else $error("start symbol not of normal length");
   a_crc_report: assert property (eod_hit && rx_bitcnt_reg == 3'h0 && rx_crc_reg != `VPW_CRC_GOOD
      |=> ##1 pend_reg.crc)
      else $error("bad residue not reported");
   a_state_clear: assert property (sv_rd && prdata_reg[7:0] == `VPW_CODE_INV && !pend_set.inv
      |=> !pend_reg.inv)
      else $error("state read did not clear invalid code");
   a_loss_stops: assert property (tx_loss && !tx_append |=> !tx_pin_reg && tx_state == TX_IDLE ##1 pend_reg.loa)
      else $error("transmit continued after lost arbitration");
   a_idle_start: assert property (tx_start |-> bus_idle && !rxd_q ##1 tx_pin_reg && tx_state == TX_SOF)
      else $error("transmit began on a busy bus");
   a_inv_loa_order: assert property (rx_evt_reg.inv && rx_evt_reg.loa |=> sv_code == `VPW_CODE_LOA && pend_reg.inv)
      else $error("loss code not ahead of invalid code");
endmodule

/* File: verification/vpw_peer_node.sv */
`timescale 1ns/1ps
// Far-side node on the wire, with shorts to supply or ground
module vpw_peer_node #(
   parameter int CLK_DIV = 10
) (
   input wire logic pclk,
   input wire logic bus_transmit_pin,
   output logic bus_receive_pin
);
   logic drive_reg = 1'b0;
   logic short_vdd = 1'b0;
   logic short_gnd = 1'b0;
   // Wired bus: active dominates unless grounded
   assign bus_receive_pin = !short_gnd && (short_vdd || drive_reg || bus_transmit_pin);
   // Hold a level for some us
   task automatic hold(input logic lvl, input int us);
      drive_reg <= lvl;
      repeat (us * CLK_DIV) @(posedge pclk);
   endtask
   // Preset ones, poly 1D, inverted remainder
   function automatic logic [7:0] crc8(input logic [7:0] q[$]);
      logic [7:0] c;
      c = 8'hFF;
      foreach (q[i])
         for (int b = 7; b >= 0; b--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i][b]) ? 8'h1D : 8'h00);
      return ~c;
   endfunction
   // Mode 1 spoils the check byte, mode 2 breaks after one byte
   task automatic send_frame(input logic [7:0] q[$], input int m, input int sh);
      logic [7:0] f[$];
      logic lvl;
      f = q;
      f.push_back(crc8(q) ^ ((m == 1) ? 8'h01 : 8'h00));
      lvl = 1'b0;
      hold(1'b0, 310);
      hold(1'b1, 200 >> sh);
      foreach (f[i]) begin
         if (m == 2 && i == 1) begin
            // Passive bit first, so the last active bit of the byte ends
            hold(1'b0, 64 >> sh);
            hold(1'b1, 300);
            break;
         end
         for (int b = 7; b >= 0; b--) begin
            hold(lvl, ((f[i][b] ^ lvl) ? 128 : 64) >> sh);
            lvl = !lvl;
         end
      end
      hold(1'b0, 200 >> sh);
   endtask
endmodule

/* File: verification/vpw_bus_protocol_handler_tb_top.sv */
`timescale 1ns/1ps
`include "vpw_defs.svh"
module vpw_bus_protocol_handler_tb_top;
   localparam int DIV = 10;
   logic pclk, tx, rx, irq, pready, pslverr, err;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd, seen;
   logic [31:0] seed = 32'h00004E5B;
   logic [7:0] q[$];
   int num_errors = 0;
   int tests_run = 0;
   int hi, n;
   vpw_protocol_handler #(.CLK_DIV(DIV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_receive_pin(rx), .bus_transmit_pin(tx), .irq(irq));
   vpw_peer_node #(.CLK_DIV(DIV)) i_peer (.pclk(pclk), .bus_transmit_pin(tx), .bus_receive_pin(rx));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic report_and_stop();
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic stop_hang();
      num_errors++;
      report_and_stop();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (pready !== 1'b1 && k++ < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k > 20) stop_hang();
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_flag(input int b);
      int k = 0;
      do apb(1'b0, `VPW_OFF_FLAGS, 32'h0);
      while (rd[b] !== 1'b1 && k++ < 15000);
      if (k > 15000) stop_hang();
   endtask
   // Count transmit-active cycles
   task automatic watch(input int us);
      hi = 0;
      repeat (us * DIV) begin
         @(posedge pclk);
         hi += (tx === 1'b1) ? 1 : 0;
      end
   endtask
   // Wait for the transmit pin to reach a level
   task automatic wait_tx(input logic v);
      n = 0;
      while (tx !== v && n++ < 5000)
         @(posedge pclk);
      if (n > 5000) stop_hang();
   endtask
   // Read state codes eight times, past empty, then clear the receive buffer
   task automatic drain(input logic [31:0] e);
      seen = 32'h0;
      repeat (8) begin
         apb(1'b0, `VPW_OFF_STATE, 32'h0);
         seen[rd[4:0]] = 1'b1;
      end
      chk("error_codes", e, seen & 32'h11100001);
      apb(1'b0, `VPW_OFF_DATA, 32'h0);
   endtask
   // Peer frame with every delivered data byte read in time
   task automatic rx_frame(input int nb, input int m, input int sh);
      logic [7:0] f[$];
      f = {};
      repeat (nb) f.push_back(rnd());
      fork
         i_peer.send_frame(f, m, sh);
         for (int i = 0; i < nb - m / 2; i++) begin
            wait_flag(`VPW_FL_RXB);
            apb(1'b0, `VPW_OFF_DATA, 32'h0);
            chk("rx_byte", {24'h0, f[i]}, rd);
         end
      join
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rchk(`VPW_OFF_CTRL1, 32'h0, "control_one");
      rchk(`VPW_OFF_CTRL2, 32'h0, "control_two");
      rchk(`VPW_OFF_FLAGS, 32'h2, "flags");
      rchk(`VPW_OFF_STATE, {24'h0, `VPW_CODE_TXE}, "state_vector");
      rchk(`VPW_OFF_STATE, 32'h0, "state_cleared");
      chk("irq_masked", 32'h0, {31'h0, irq});
      rchk(8'h14, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'b1, `VPW_OFF_CTRL1, 32'h1);
      rchk(`VPW_OFF_CTRL1, 32'h1, "control_one_rw");
      // Own two-byte frame looped back while the wire is grounded
      apb(1'b1, `VPW_OFF_CTRL2, 32'h1);
      i_peer.short_gnd <= 1'b1;
      q = {rnd(), rnd()};
      apb(1'b1, `VPW_OFF_DATA, {24'h0, q[0]});
      wait_tx(1'b1);
      watch(250);
      chk("sof_len", 32'h1, {31'h0, hi > 1980 && hi <= 2000});
      wait_flag(`VPW_FL_TXE);
      apb(1'b1, `VPW_OFF_DATA, {24'h0, q[1]});
      foreach (q[i]) begin
         wait_flag(`VPW_FL_RXB);
         chk("irq_raised", 32'h1, {31'h0, irq});
         apb(1'b0, `VPW_OFF_DATA, 32'h0);
         chk("own_byte", {24'h0, q[i]}, rd);
      end
      repeat (1200 * DIV) @(posedge pclk);
      drain(32'h1);
      // Fourfold frame with a spoiled check byte, then a break
      i_peer.short_gnd <= 1'b0;
      apb(1'b1, `VPW_OFF_CTRL2, 32'h2);
      rx_frame(2, 1, 2);
      drain(32'h01000001);
      apb(1'b1, `VPW_OFF_CTRL2, 32'h0);
      rx_frame(2, 2, 0);
      drain(32'h10000001);
      // Wire shorted to ground
      i_peer.short_gnd <= 1'b1;
      apb(1'b1, `VPW_OFF_DATA, {24'h0, rnd()});
      watch(400);
      chk("gnd_abort", 32'h1, {31'h0, hi > 0 && hi < 2000});
      drain(32'h10000001);
      i_peer.short_gnd <= 1'b0;
      watch(400);
      chk("no_retry", 32'h0, hi);
      // Peer pulls the wire active inside a recessive bit
      apb(1'b1, `VPW_OFF_DATA, 32'h000000FF);
      wait_tx(1'b1);
      wait_tx(1'b0);
      i_peer.hold(1'b0, 64);
      i_peer.hold(1'b1, 64);
      i_peer.hold(1'b0, 1);
      watch(200);
      chk("loss_quiet", 32'h0, hi);
      drain(32'h10100001);
      // Wire shorted to supply, then released
      i_peer.short_vdd <= 1'b1;
      q = {rnd()};
      apb(1'b1, `VPW_OFF_DATA, {24'h0, q[0]});
      watch(400);
      chk("vdd_hold", 32'h0, hi);
      i_peer.short_vdd <= 1'b0;
      wait_flag(`VPW_FL_RXB);
      apb(1'b0, `VPW_OFF_DATA, 32'h0);
      chk("resume_byte", {24'h0, q[0]}, rd);
      report_and_stop();
   end
endmodule
